// ---- verilog/eeprom_rd_pkg.sv ----
package eeprom_rd_pkg;
    // ----------------------------------------------
    // device address byte layout
    // ----------------------------------------------
    localparam logic [3:0] TYPE_ARRAY   = 4'ha; // main array
    localparam logic [3:0] TYPE_SPECIAL = 4'hb; // page / serial
    localparam int         TYPE_HI      = 7;
    localparam int         TYPE_LO      = 4;
    localparam int         STRAP_HI     = 3;
    localparam int         STRAP_LO     = 1;
    localparam int         RW_BIT       = 0;

    // ----------------------------------------------
    // word address layout (high byte)
    // ----------------------------------------------
    localparam int         REGION_HI    = 2;  // region_select_bits
    localparam int         REGION_LO    = 1;
    localparam int         ARRAY_HI_W   = 6;  // array bits in high byte
    localparam logic [1:0] REG_PARAM    = 2'h0;
    localparam logic [1:0] REG_SERIAL   = 2'h1;

    // ----------------------------------------------
    // sizes, masks, counts
    // ----------------------------------------------
    localparam int                ADDR_W       = 14;
    localparam int                ARRAY_BYTES  = 16384;
    localparam int                PARAM_BYTES  = 64;
    localparam int                PARAM_OFS_W  = 6;
    localparam int                SERIAL_OFS_W = 4;
    localparam int                SERIAL_W     = 128;
    localparam logic [ADDR_W-1:0] ARRAY_LAST   = 14'h3fff;
    localparam logic [ADDR_W-1:0] PARAM_LAST   = 14'h003f;
    localparam logic [ADDR_W-1:0] SERIAL_LAST  = 14'h000f;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 14'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE     = 14'h0001;
    localparam logic [3:0]        BYTE_BITS    = 4'h8;
    localparam logic [3:0]        CNT_RST      = 4'h0;
    localparam logic [3:0]        CNT_ONE      = 4'h1;

    // protocol states
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_DEV      = 4'h1,
        ST_ACK_DEV  = 4'h2,
        ST_WHI      = 4'h3,
        ST_ACK_WHI  = 4'h4,
        ST_WLO      = 4'h5,
        ST_ACK_WLO  = 4'h6,
        ST_WDAT     = 4'h7,
        ST_ACK_WDAT = 4'h8,
        ST_RDAT     = 4'h9,
        ST_RACK     = 4'ha
    } state_e;

    // which store the shared counter points into
    typedef enum logic [1:0] {
        SEL_ARRAY  = 2'h0,
        SEL_PARAM  = 2'h1,
        SEL_SERIAL = 2'h2
    } sel_e;

    // wrap mask of each store
    function automatic logic [ADDR_W-1:0] sel_mask(input sel_e sel);
        case (sel)
            SEL_PARAM:  sel_mask = PARAM_LAST;
            SEL_SERIAL: sel_mask = SERIAL_LAST;
            default:    sel_mask = ARRAY_LAST;
        endcase
    endfunction

    // counter step with wrap inside the store
    function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a,
                                                   input sel_e sel);
        addr_inc = (a + ADDR_ONE) & sel_mask(sel);
    endfunction
endpackage

// ---- verilog/eeprom_i2c_read_path.sv ----
`timescale 1ns/1ps
module eeprom_i2c_read_path
    import eeprom_rd_pkg::*;
#(
    // arbitrary value, stands in for factory data
    parameter logic [SERIAL_W-1:0] SERIAL_VALUE =
        128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
    input  logic              ref_clk,
    input  logic              rst_n,
    input  logic              clk_en,
    input  logic              scl,
    input  logic              sda_in,
    output logic              sda_out,
    output logic              sda_oe_n,
    input  logic              strap_addr_bit0,
    input  logic              strap_addr_bit1,
    input  logic              strap_addr_bit2,
    input  logic              write_busy,
    input  logic              param_locked,
    input  logic              fill_en,
    input  sel_e              fill_sel,
    input  logic [ADDR_W-1:0] fill_addr,
    input  logic [7:0]        fill_data
);
    // ----------------------------------------------
    // state
    // ----------------------------------------------
    logic [1:0]        scl_sy;       // scl synchroniser
    logic [1:0]        sda_sy;       // sda synchroniser
    logic [2:0]        strap_s1;     // strap first stage
    logic [2:0]        strap_s2;     // strap second stage
    logic              scl_d;        // scl one later, edges
    logic              sda_d;        // sda one later, edges
    state_e            state_reg;    // protocol state
    logic [3:0]        bit_cnt_reg;  // bits in current byte
    logic [7:0]        shift_reg;    // received byte
    logic [7:0]        tx_reg;       // byte being sent
    logic [7:0]        hi_reg;       // first word address byte
    logic              special_reg;  // special type selector seen
    logic              rw_reg;       // read bit of address byte
    logic              mack_reg;     // controller acked last byte
    logic [ADDR_W-1:0] addr_reg;     // shared address counter
    sel_e              sel_reg;      // store the counter is in
    sel_e              rd_sel_reg;   // store being read
    logic              oe_n_reg;     // sda pull-down, low drives
    logic              out_reg;      // sda output level
    logic [7:0]        array_mem [0:ARRAY_BYTES-1]; // main array
    logic [7:0]        param_mem [0:PARAM_BYTES-1]; // param page

    // decoded events
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic              byte_end;
    logic              dev_match;
    logic              data_ok;
    logic              ack_now;
    logic              ld_byte;
    logic              dev_read_end;
    logic              wlo_end;
    logic              lock_region;
    logic [ADDR_W-1:0] new_addr;
    sel_e              new_sel;
    logic [7:0]        rd_byte;
    logic [SERIAL_W-1:0] serial_shift;

    assign sda_oe_n = oe_n_reg;
    assign sda_out  = out_reg;

    // ----------------------------------------------
    // pin synchronisers
    // ----------------------------------------------
    // idle bus is high, so reset to one to avoid a false start
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sy   <= '1;
            sda_sy   <= '1;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            strap_s1 <= '0;
            strap_s2 <= '0;
        end else if (clk_en) begin
            scl_sy   <= {scl_sy[0], scl};
            sda_sy   <= {sda_sy[0], sda_in};
            scl_d    <= scl_sy[1];
            sda_d    <= sda_sy[1];
            strap_s1 <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
            strap_s2 <= strap_s1;
        end
    end

    // edges and bus conditions, all from the second stage
    assign scl_rise  = scl_sy[1] & ~scl_d;
    assign scl_fall  = ~scl_sy[1] & scl_d;
    assign start_det = scl_sy[1] & scl_d & ~sda_sy[1] & sda_d;
    assign stop_det  = scl_sy[1] & scl_d & sda_sy[1] & ~sda_d;
    assign byte_end  = scl_fall && (bit_cnt_reg == BYTE_BITS);

    // ----------------------------------------------
    // decode of received bytes
    // ----------------------------------------------
    // no guard pin input: reads never look at write protection
    // a busy write cycle hides the device entirely
    assign dev_match = ((shift_reg[TYPE_HI:TYPE_LO] == TYPE_ARRAY) ||
                        (shift_reg[TYPE_HI:TYPE_LO] == TYPE_SPECIAL)) &&
                       (shift_reg[STRAP_HI:STRAP_LO] == strap_s2) &&
                       !write_busy;

    // lock region is a write-path command, its data is refused here
    assign lock_region = special_reg && hi_reg[REGION_HI];

    // data byte answer: locked page or serial block refuse it
    assign data_ok = !(lock_region ||
                       (special_reg && sel_reg == SEL_SERIAL) ||
                       (special_reg && sel_reg == SEL_PARAM &&
                        param_locked));

    // ack slot decision at the eighth bit of a received byte
    always_comb begin
        ack_now = 1'b0;
        if (byte_end) begin
            case (state_reg)
                ST_DEV:  ack_now = dev_match;
                ST_WHI:  ack_now = 1'b1;
                ST_WLO:  ack_now = 1'b1;
                ST_WDAT: ack_now = data_ok;
                default: ack_now = 1'b0;
            endcase
        end
    end

    // a data byte is loaded for sending on these falls
    assign ld_byte = scl_fall &&
                     ((state_reg == ST_ACK_DEV && rw_reg) ||
                      (state_reg == ST_RACK && mack_reg));
    assign dev_read_end = byte_end && state_reg == ST_DEV &&
                          dev_match && shift_reg[RW_BIT];
    assign wlo_end = byte_end && state_reg == ST_WLO;

    // target of a dummy write: region picks the store
    always_comb begin
        new_sel  = SEL_ARRAY;
        new_addr = {hi_reg[ARRAY_HI_W-1:0], shift_reg};
        if (special_reg) begin
            if (hi_reg[REGION_HI:REGION_LO] == REG_SERIAL) begin
                new_sel = SEL_SERIAL;
            end else begin
                new_sel = SEL_PARAM;
            end
        end
        new_addr = new_addr & sel_mask(new_sel);
    end

    // byte at the counter; serial byte 0 is the top of the value
    always_comb begin
        serial_shift = SERIAL_VALUE << {addr_reg[SERIAL_OFS_W-1:0], 3'h0};
        case (rd_sel_reg)
            SEL_PARAM:  rd_byte = param_mem[addr_reg[PARAM_OFS_W-1:0]];
            SEL_SERIAL: rd_byte = serial_shift[SERIAL_W-1 -: 8];
            default:    rd_byte = array_mem[addr_reg];
        endcase
    end

    // ----------------------------------------------
    // protocol sequencer
    // ----------------------------------------------
    // a start anywhere restarts decoding and drops any pending write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= CNT_RST;
            shift_reg   <= '0;
            tx_reg      <= '0;
            hi_reg      <= '0;
            special_reg <= 1'b0;
            rw_reg      <= 1'b0;
            mack_reg    <= 1'b0;
        end else if (clk_en) begin
            if (start_det) begin
                state_reg   <= ST_DEV;
                bit_cnt_reg <= CNT_RST;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    // receiving a byte from the controller
                    ST_DEV, ST_WHI, ST_WLO, ST_WDAT: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_sy[1]};
                            bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
                        end else if (byte_end) begin
                            // nack: wait for the next start
                            state_reg <= ack_now ? state_e'(state_reg + CNT_ONE)
                                                 : ST_IDLE;
                            if (state_reg == ST_DEV) begin
                                special_reg <= shift_reg[TYPE_HI:TYPE_LO] ==
                                               TYPE_SPECIAL;
                                rw_reg      <= shift_reg[RW_BIT];
                            end
                            if (state_reg == ST_WHI) begin
                                hi_reg <= shift_reg;
                            end
                        end
                    end
                    // address acked: read sends, write takes address
                    ST_ACK_DEV: begin
                        if (scl_fall && rw_reg) begin
                            state_reg   <= ST_RDAT;
                            tx_reg      <= rd_byte;
                            bit_cnt_reg <= CNT_ONE;
                        end else if (scl_fall) begin
                            state_reg   <= ST_WHI;
                            bit_cnt_reg <= CNT_RST;
                        end
                    end
                    ST_ACK_WHI: begin
                        if (scl_fall) begin
                            state_reg   <= ST_WLO;
                            bit_cnt_reg <= CNT_RST;
                        end
                    end
                    // data bytes are taken but not stored here
                    ST_ACK_WLO, ST_ACK_WDAT: begin
                        if (scl_fall) begin
                            state_reg   <= ST_WDAT;
                            bit_cnt_reg <= CNT_RST;
                        end
                    end
                    // sending, msb first
                    ST_RDAT: begin
                        if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
                            state_reg <= ST_RACK;
                        end else if (scl_fall) begin
                            tx_reg      <= {tx_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
                        end
                    end
                    // controller answer: ack goes on, nack stops
                    ST_RACK: begin
                        if (scl_rise) begin
                            mack_reg <= !sda_sy[1];
                        end else if (scl_fall && mack_reg) begin
                            state_reg   <= ST_RDAT;
                            tx_reg      <= rd_byte;
                            bit_cnt_reg <= CNT_ONE;
                        end else if (scl_fall) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------
    // shared address counter
    // ----------------------------------------------
    // one counter for all stores; reset stands for power-up only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg   <= ADDR_RST;
            sel_reg    <= SEL_ARRAY;
            rd_sel_reg <= SEL_ARRAY;
        end else if (clk_en) begin
            if (wlo_end && !lock_region) begin
                addr_reg <= new_addr;
                sel_reg  <= new_sel;
            end else if (dev_read_end) begin
                // special reads stay in serial only if the counter is there, else read the page
                if (shift_reg[TYPE_HI:TYPE_LO] == TYPE_SPECIAL) begin
                    rd_sel_reg <= (sel_reg == SEL_SERIAL) ? SEL_SERIAL
                                                          : SEL_PARAM;
                    sel_reg    <= (sel_reg == SEL_SERIAL) ? SEL_SERIAL
                                                          : SEL_PARAM;
                end else begin
                    rd_sel_reg <= SEL_ARRAY;
                    sel_reg    <= SEL_ARRAY;
                end
            end else if (ld_byte) begin
                addr_reg <= addr_inc(addr_reg, rd_sel_reg);
            end
        end
    end

    // ----------------------------------------------
    // sda driver
    // ----------------------------------------------
    // only pulls low; changes only after an scl fall
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_reg <= 1'b1;
            out_reg  <= 1'b0;
        end else if (clk_en) begin
            if (start_det || stop_det) begin
                oe_n_reg <= 1'b1;
            end else if (ack_now) begin
                oe_n_reg <= 1'b0;
            end else if (ld_byte) begin
                oe_n_reg <= rd_byte[7];
            end else if (state_reg == ST_RDAT && scl_fall) begin
                oe_n_reg <= (bit_cnt_reg == BYTE_BITS) ? 1'b1 : tx_reg[6];
            end else if (scl_fall) begin
                oe_n_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------
    // store fill port (write path side)
    // ----------------------------------------------
    // the serial block has no write port at all
    always_ff @(posedge ref_clk) begin
        if (clk_en && fill_en) begin
            if (fill_sel == SEL_ARRAY) begin
                array_mem[fill_addr] <= fill_data;
            end else if (fill_sel == SEL_PARAM) begin
                param_mem[fill_addr[PARAM_OFS_W-1:0]] <= fill_data;
            end
        end
    end

    // ----------------------------------------------
    // assertions
    // ----------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    sequence s_dev_end;
        byte_end && state_reg == ST_DEV;
    endsequence
    sequence s_dat_end;
        byte_end && state_reg == ST_WDAT;
    endsequence

    property p_dev_ack;
        s_dev_end and dev_match |=> !sda_oe_n && state_reg == ST_ACK_DEV;
    endproperty
    a_dev_ack: assert property (p_dev_ack) else $error("no address ack");

    property p_busy_nack;
        s_dev_end and write_busy |=> sda_oe_n && state_reg == ST_IDLE;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("busy acked");

    property p_arr_inc;
        ld_byte && rd_sel_reg == SEL_ARRAY |=> addr_reg == $past(addr_reg) + ADDR_ONE;
    endproperty
    a_arr_inc: assert property (p_arr_inc) else $error("no increment");

    property p_arr_wrap;
        ld_byte && rd_sel_reg == SEL_ARRAY && addr_reg == ARRAY_LAST
            |=> addr_reg == ADDR_RST;
    endproperty
    a_arr_wrap: assert property (p_arr_wrap) else $error("array wrap");

    property p_param_wrap;
        ld_byte && rd_sel_reg == SEL_PARAM && addr_reg == PARAM_LAST
            |=> addr_reg == ADDR_RST;
    endproperty
    a_param_wrap: assert property (p_param_wrap) else $error("page wrap");

    property p_serial_wrap;
        ld_byte && rd_sel_reg == SEL_SERIAL && addr_reg == SERIAL_LAST
            |=> addr_reg == ADDR_RST;
    endproperty
    a_serial_wrap: assert property (p_serial_wrap) else $error("serial wrap");

    property p_seq_go;
        state_reg == ST_RACK && mack_reg && scl_fall
            |=> state_reg == ST_RDAT && bit_cnt_reg == CNT_ONE;
    endproperty
    a_seq_go: assert property (p_seq_go) else $error("read stopped");

    property p_lock_nack;
        s_dat_end and (special_reg && sel_reg == SEL_PARAM && param_locked)
            |=> sda_oe_n && state_reg == ST_IDLE;
    endproperty
    a_lock_nack: assert property (p_lock_nack) else $error("locked acked");

    property p_serial_ro;
        s_dat_end and (special_reg && sel_reg == SEL_SERIAL) |=> sda_oe_n;
    endproperty
    a_serial_ro: assert property (p_serial_ro) else $error("serial write acked");

    property p_start_reset;
        start_det |=> state_reg == ST_DEV && bit_cnt_reg == CNT_RST ##1 sda_oe_n;
    endproperty
    a_start_reset: assert property (p_start_reset) else $error("start ignored");

    property p_scl_low;
        $changed(sda_oe_n) |-> !scl_d;
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("sda moved, scl high");

    property p_msb_first;
        state_reg == ST_RDAT && scl_fall && bit_cnt_reg != BYTE_BITS
            |=> sda_oe_n == $past(tx_reg[6]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("bit order");
endmodule

// ---- testbench/i2c_ctrl_model.sv ----
`timescale 1ns/1ps
// bus controller model: drives scl, only ever pulls sda low
module i2c_ctrl_model (
    input  wire logic ref_clk,  // bench clock
    input  wire logic sda,      // resolved data wire
    output logic      scl,      // stands high between frames
    output logic      sda_pull  // high = pull sda low
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    // wait n bench clocks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // one scl period, 4 clocks low then 4 high; data moves only while scl low
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_pull <= ~b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl <= 1'b0;
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        tick(1);
        sda_pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    // stop: sda rises while scl high, bus left idle
    task automatic stop();
        tick(1);
        sda_pull <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b0;
        tick(4);
    endtask
    // byte out msb first, ninth slot gives the device answer
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // byte in msb first; last byte answered with nack
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~more, r);
    endtask
endmodule

// ---- testbench/eeprom_i2c_read_path_test.sv ----
`timescale 1ns/1ps
module eeprom_i2c_read_path_test;
    import eeprom_rd_pkg::*;
    // arbitrary serial contents, handed to the design
    localparam logic [SERIAL_W-1:0] SER = 128'h5a3c_9e01_7f42_b6d8_13c5_e70a_2b94_6f1d;
    logic ref_clk = 1'b0, rst_n = 1'b0, write_busy = 1'b0, param_locked = 1'b0;
    logic fill_en = 1'b0, scl, sda_pull, sda_out, sda_oe_n, k;
    logic [2:0]        strap = 3'h0;             // strap pins
    sel_e              fill_sel = SEL_ARRAY;
    logic [ADDR_W-1:0] fill_addr = 14'h0000;
    logic [7:0]        fill_data = 8'h00, d;
    logic [7:0]        arr[ARRAY_BYTES];          // expected array
    logic [7:0]        pg[PARAM_BYTES];           // expected page
    int                errors = 0, checked = 0, a;
    // open drain wire with pull-up; an enabled driver shows sda_out, which must be low
    wire sda = (sda_pull || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
    always #50 ref_clk = ~ref_clk;
    eeprom_i2c_read_path #(.SERIAL_VALUE(SER)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(1'b1), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
        .write_busy(write_busy), .param_locked(param_locked), .fill_en(fill_en),
        .fill_sel(fill_sel), .fill_addr(fill_addr), .fill_data(fill_data));
    i2c_ctrl_model i_ctl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
    // expected byte of a store, offsets wrap at the store size
    function automatic logic [7:0] exp_byte(input sel_e s, input int o);
        case (s)
            SEL_PARAM:  return pg[o % PARAM_BYTES];
            SEL_SERIAL: return SER[127 - 8 * (o % 16) -: 8];
            default:    return arr[o % ARRAY_BYTES];
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // dummy write presetting the counter, no stop after it
    task automatic point(input logic [3:0] t, input logic [7:0] hi, input logic [7:0] lo);
        i_ctl.start();
        i_ctl.send({t, strap, 1'b0}, k);
        check({7'h0, k}, 8'h01);
        i_ctl.send(hi, k);
        check({7'h0, k}, 8'h01);
        i_ctl.send(lo, k);
        check({7'h0, k}, 8'h01);
    endtask
    // (repeated) start, read header, n bytes then nack and stop
    task automatic read(input logic [3:0] t, input sel_e s, input int o, input int n);
        i_ctl.start();
        i_ctl.send({t, strap, 1'b1}, k);
        check({7'h0, k}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_ctl.recv(i < n - 1, d);
            check(d, exp_byte(s, o + i));
        end
        i_ctl.stop();
    endtask
    task automatic finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // watchdog, well beyond the expected run of about 2.3 ms
    initial begin
        #6_000_000;
        errors++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h7e62));
        strap <= 3'($urandom);
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        // preload array and page through the fill port, one byte a cycle
        for (int j = 0; j < ARRAY_BYTES + PARAM_BYTES; j++) begin
            d = 8'($urandom);
            fill_en   <= 1'b1;
            fill_sel  <= (j < ARRAY_BYTES) ? SEL_ARRAY : SEL_PARAM;
            fill_addr <= ADDR_W'(j % ARRAY_BYTES);
            fill_data <= d;
            if (j < ARRAY_BYTES) arr[j] = d;
            else pg[j - ARRAY_BYTES] = d;
            @(posedge ref_clk);
        end
        fill_en <= 1'b0;
        // refused headers: wrong straps, wrong type, busy writing
        for (int c = 0; c < 3; c++) begin
            write_busy <= (c == 2);
            i_ctl.start();
            i_ctl.send({(c == 1) ? 4'h9 : TYPE_ARRAY, (c == 0) ? ~strap : strap, 1'b1}, k);
            check({7'h0, k}, 8'h00);
            i_ctl.stop();
        end
        write_busy <= 1'b0;
        // random reads, the first one across the array end
        for (int j = 0; j < 3; j++) begin
            a = (j == 0) ? ARRAY_BYTES - 2 : int'($urandom % ARRAY_BYTES);
            point(TYPE_ARRAY, {2'($urandom), a[13:8]}, a[7:0]);
            read(TYPE_ARRAY, SEL_ARRAY, a, 4);
        end
        read(TYPE_ARRAY, SEL_ARRAY, a + 4, 2);
        // page read across its end, don't-care bits random
        point(TYPE_SPECIAL, {5'($urandom), REG_PARAM, 1'($urandom)}, {2'($urandom), 6'h3e});
        read(TYPE_SPECIAL, SEL_PARAM, 62, 3);
        read(TYPE_ARRAY, SEL_ARRAY, 1, 1);
        // special current read after an array access reads the page at the shared counter
        read(TYPE_SPECIAL, SEL_PARAM, 2, 1);
        // whole serial block from offset 0 plus one wrapped byte
        point(TYPE_SPECIAL, {5'($urandom), REG_SERIAL, 1'($urandom)}, {4'($urandom), 4'h0});
        read(TYPE_SPECIAL, SEL_SERIAL, 0, 17);
        // serial data byte is always refused
        point(TYPE_SPECIAL, {5'h00, REG_SERIAL, 1'b0}, 8'h05);
        i_ctl.send(8'($urandom), k);
        check({7'h0, k}, 8'h00);
        i_ctl.stop();
        // lock status query unlocked then locked, then a page read
        for (int c = 0; c < 2; c++) begin
            param_locked <= c[0];
            point(TYPE_SPECIAL, 8'h00, 8'h00);
            i_ctl.send(8'($urandom), k);
            check({7'h0, k}, {7'h0, ~c[0]});
            i_ctl.start();
            i_ctl.stop();
            a = int'($urandom % PARAM_BYTES);
            point(TYPE_SPECIAL, {5'h00, REG_PARAM, 1'b0}, {2'h0, a[5:0]});
            read(TYPE_SPECIAL, SEL_PARAM, a, 2);
        end
        finish_test();
    end
endmodule
